// file: design/bridge_drive_pkg.sv
// constants for the transformer bridge drive control block
// assumes a single 25 MHz system clock
package bridge_drive_pkg;
  localparam int clock_mhz = 25;
  // stall timeout window, microseconds
  localparam int stall_timeout_min_us = 14;
  localparam int stall_timeout_max_us = 56;
  // watchdog fires at the documented minimum, exactly 350 cycles; well inside the maximum
  localparam int stall_timeout_cycles = stall_timeout_min_us * clock_mhz;
  localparam int disable_max_us = 56;
  localparam int disable_cycles = disable_max_us * clock_mhz;
  // switching frequency range, kHz
  localparam int fsw_min_khz = 150;
  localparam int fsw_max_khz = 1000;
  // toggle rate is twice the switching frequency; half period in cycles
  localparam int half_period_fast = (clock_mhz * 1000) / (2 * fsw_max_khz);
  localparam int half_period_slow = (clock_mhz * 1000) / (2 * fsw_min_khz);
  localparam int rate_w = 8;
  localparam int count_w = 12;
  localparam logic [rate_w-1:0] rate_max = 8'hff;
  // dead time: 10 ns rounds up to one 40 ns cycle
  localparam int dead_time_ns = 10;
  localparam int clock_period_ns = 40;
  localparam int dead_cycles = (dead_time_ns + clock_period_ns - 1) / clock_period_ns;
  localparam logic [count_w-1:0] count_zero = 12'h000;
  localparam logic [count_w-1:0] count_one = 12'h001;
  typedef enum logic [1:0] {
    st_off = 2'b00,
    st_dead = 2'b01,
    st_run = 2'b10
  } drive_state_t;
endpackage : bridge_drive_pkg

// file: design/rate_oscillator.sv
// programmable switching oscillator: toggle enable pulse at twice fsw
// assumes rate is a quasi-static setting from the same clock domain
`timescale 1ns/10ps
module rate_oscillator (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // control
  input wire logic run,
  input wire logic [bridge_drive_pkg::rate_w-1:0] rate,
  // toggle enable pulse
  output logic tick
);
  logic [bridge_drive_pkg::count_w-1:0] count_reg, count_next, limit;

  // linear map: rate 0 is fastest, rate max gives the lowest frequency
  always_comb begin
    limit = bridge_drive_pkg::count_w'(bridge_drive_pkg::half_period_fast
      + ((bridge_drive_pkg::half_period_slow - bridge_drive_pkg::half_period_fast)
      * int'(rate)) / int'(bridge_drive_pkg::rate_max));
    count_next = count_reg;
    tick = 1'b0;
    if (!run) begin
      count_next = bridge_drive_pkg::count_zero;
    end else if (count_reg >= limit - bridge_drive_pkg::count_one) begin
      count_next = bridge_drive_pkg::count_zero;
      tick = 1'b1;
    end else begin
      count_next = count_reg + bridge_drive_pkg::count_one;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_reg <= bridge_drive_pkg::count_zero;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : rate_oscillator

// file: design/transformer_bridge_drive_control.sv
// top of the transformer bridge drive control: source select, toggle stage,
// watchdog, protection gating and break-before-make output sequencing
// assumes mode, clock_or_rate_pin and fault flags arrive asynchronously
`timescale 1ns/10ps
module transformer_bridge_drive_control (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // pins from the controller
  input wire logic mode,
  input wire logic clock_or_rate_pin,
  // internal oscillator setting
  input wire logic [bridge_drive_pkg::rate_w-1:0] rate_setting,
  // protection indications
  input wire logic under_voltage,
  input wire logic over_temp,
  // transformer drive
  output logic drive_out_a,
  output logic drive_out_b,
  output logic enabled
);
  // two-stage synchronisers for the four asynchronous inputs
  logic [3:0] sync1_reg, sync2_reg, prev_pin_reg;
  logic mode_s, pin_s, uv_s, ot_s;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {over_temp, under_voltage, clock_or_rate_pin, mode};
      sync2_reg <= sync1_reg;
    end
  end

  assign mode_s = sync2_reg[0];
  assign pin_s = sync2_reg[1];
  assign uv_s = sync2_reg[2];
  assign ot_s = sync2_reg[3];

  // edge detection on the synchronised pin only
  logic pin_last_reg, pin_rise, pin_change;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_last_reg <= 1'b0;
    end else begin
      pin_last_reg <= pin_s;
    end
  end
  assign pin_rise = pin_s && !pin_last_reg;
  assign pin_change = pin_s != pin_last_reg;

  // internal oscillator runs only while internal mode is selected
  logic osc_tick;
  rate_oscillator u_osc (
    .clock(clock),
    .resetn(resetn),
    .run(mode_s),
    .rate(rate_setting),
    .tick(osc_tick)
  );

  // watchdog on pin level; a stuck pin in external mode stops the drive
  logic [15:0] stall_reg, stall_next;
  logic stalled_reg, stalled_next;
  localparam logic [15:0] stall_limit = 16'(bridge_drive_pkg::stall_timeout_cycles);
  always_comb begin
    stall_next = stall_reg;
    stalled_next = stalled_reg;
    if (mode_s) begin
      stall_next = 16'h0000;
      stalled_next = 1'b0;
    end else if (pin_rise) begin
      stall_next = 16'h0000;
      stalled_next = 1'b0;
    end else if (pin_change) begin
      stall_next = 16'h0000;
    end else if (stall_reg >= stall_limit) begin
      stalled_next = 1'b1;
    end else begin
      stall_next = stall_reg + 16'h0001;
    end
  end
  // a mode drop starts the external-mode stall count from zero, so the drive stops
  // within the timeout, well inside 56 us

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stall_reg <= 16'h0000;
      stalled_reg <= 1'b1;
    end else begin
      stall_reg <= stall_next;
      stalled_reg <= stalled_next;
    end
  end

  // thermal flag held until the indication clears (hysteresis sits in the sensor)
  logic hot_reg, hot_next;
  always_comb begin
    hot_next = hot_reg;
    if (ot_s) begin
      hot_next = 1'b1;
    end else begin
      hot_next = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hot_reg <= 1'b1;
    end else begin
      hot_reg <= hot_next;
    end
  end

  // source select; external edges only from rising pin transitions
  logic src_tick, allow;
  always_comb begin
    if (mode_s) begin
      src_tick = osc_tick;
    end else begin
      src_tick = pin_rise;
    end
  end
  assign allow = !uv_s && !hot_reg && (mode_s || !stalled_next);

  // toggle stage plus break-before-make sequencer
  bridge_drive_pkg::drive_state_t state_reg, state_next;
  logic phase_reg, phase_next;
  logic [3:0] dead_reg, dead_next;
  logic out_a_reg, out_a_next, out_b_reg, out_b_next;
  localparam logic [3:0] dead_limit = 4'(bridge_drive_pkg::dead_cycles);

  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    dead_next = dead_reg;
    out_a_next = 1'b0;
    out_b_next = 1'b0;
    case (state_reg)
      bridge_drive_pkg::st_off: begin
        dead_next = 4'h0;
        if (allow && src_tick) begin
          phase_next = !phase_reg;
          state_next = bridge_drive_pkg::st_dead;
        end
      end
      bridge_drive_pkg::st_dead: begin
        // both legs off for the dead time
        if (!allow) begin
          state_next = bridge_drive_pkg::st_off;
        end else if (dead_reg + 4'h1 >= dead_limit) begin
          state_next = bridge_drive_pkg::st_run;
          out_a_next = phase_reg;
          out_b_next = !phase_reg;
        end else begin
          dead_next = dead_reg + 4'h1;
        end
      end
      bridge_drive_pkg::st_run: begin
        out_a_next = out_a_reg;
        out_b_next = out_b_reg;
        if (!allow) begin
          out_a_next = 1'b0;
          out_b_next = 1'b0;
          state_next = bridge_drive_pkg::st_off;
        end else if (src_tick) begin
          // one tick halves the source: a full output cycle takes two
          phase_next = !phase_reg;
          dead_next = 4'h0;
          out_a_next = 1'b0;
          out_b_next = 1'b0;
          state_next = bridge_drive_pkg::st_dead;
        end
      end
      default: begin
        state_next = bridge_drive_pkg::st_off;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= bridge_drive_pkg::st_off;
      phase_reg <= 1'b0;
      dead_reg <= 4'h0;
      out_a_reg <= 1'b0;
      out_b_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      dead_reg <= dead_next;
      out_a_reg <= out_a_next;
      out_b_reg <= out_b_next;
    end
  end

  assign drive_out_a = out_a_reg;
  assign drive_out_b = out_b_reg;
  assign enabled = state_reg == bridge_drive_pkg::st_run;
endmodule : transformer_bridge_drive_control

// file: sim/bridge_drive_checker.sv
// checker for the bridge drive block
// bound to the top; pins change off the falling edge
`timescale 1ns/10ps
module bridge_drive_checker (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // inputs
  input wire logic mode,
  input wire logic clock_or_rate_pin,
  input wire logic under_voltage,
  input wire logic over_temp,
  // outputs
  input wire logic drive_out_a,
  input wire logic drive_out_b,
  input wire logic enabled
);
  logic [3:0] age_reg;
  logic [10:0] stall_reg;
  logic quiet;
  assign quiet = !mode && !under_voltage && !over_temp;
  // saturating counts keep the helpers small
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      age_reg <= 4'hf;
      stall_reg <= 11'h000;
    end else begin
      age_reg <= $rose(clock_or_rate_pin) ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
      stall_reg <= (mode || $changed(clock_or_rate_pin)) ? 11'h000 :
        stall_reg + {10'h000, stall_reg != 11'h578};
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  chk_out_antiphase: assert property (enabled && $past(enabled) |-> drive_out_a != drive_out_b)
    else $error("outputs not in antiphase");
  chk_idle_low: assert property (!enabled [*2] |-> !drive_out_a && !drive_out_b)
    else $error("output high while off");
  chk_dead_gap: assert property ($rose(drive_out_a) || $rose(drive_out_b) |-> !$past(drive_out_a || drive_out_b))
    else $error("no dead time");
  chk_uv_lockout: assert property (under_voltage [*6] |-> !drive_out_a && !drive_out_b)
    else $error("driving in lockout");
  chk_thermal_off: assert property (over_temp [*6] |-> !enabled)
    else $error("driving while hot");
  chk_edge_only: assert property (quiet [*8] ##0 ($rose(drive_out_a) || $rose(drive_out_b)) |-> age_reg inside {[4'h2:4'h7]})
    else $error("switch without pin edge");
  chk_div_two: assert property (quiet [*8] ##0 (enabled && $rose(clock_or_rate_pin)) |-> ##[2:7] ($rose(drive_out_a) || $rose(drive_out_b)))
    else $error("pin edge lost");
  chk_stall_off: assert property (stall_reg == 11'h578 |-> !enabled && !drive_out_a)
    else $error("stall not caught");
  chk_edge_resume: assert property (quiet [*8] ##0 $rose(clock_or_rate_pin) |-> ##[2:8] enabled)
    else $error("no resume on edge");
endmodule : bridge_drive_checker
bind transformer_bridge_drive_control bridge_drive_checker u_chk (.clock(clock),
  .resetn(resetn), .mode(mode), .clock_or_rate_pin(clock_or_rate_pin),
  .under_voltage(under_voltage), .over_temp(over_temp), .drive_out_a(drive_out_a),
  .drive_out_b(drive_out_b), .enabled(enabled));

// file: sim/clock_source_model.sv
// external clock source for the clock/rate pin
// half period given in system cycles, at least 2
`timescale 1ns/10ps
module clock_source_model (
  // clock
  input wire logic clock,
  // control
  input wire logic run,
  input wire logic [7:0] half_cycles,
  // pin
  output logic pin
);
  int count = 0;
  initial pin = 1'b0;
  always @(negedge clock) begin
    if (!run) begin
      // stopping is how the far side asks for disable; pull-down holds it low
      pin <= 1'b0;
      count <= 0;
    end else if (count + 1 >= int'(half_cycles)) begin
      pin <= !pin;
      count <= 0;
    end else begin
      count <= count + 1;
    end
  end
endmodule : clock_source_model

// file: sim/tb.sv
// bench for the bridge drive block
// 25 MHz clock; inputs change on the falling edge
`timescale 1ns/10ps
module tb;
  typedef struct {logic md; logic [7:0] rt; logic [7:0] hf; int span;} row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic mode = 1'b1;
  logic run = 1'b0;
  logic [7:0] half = 8'h0a;
  logic [7:0] rate = 8'h00;
  logic uv = 1'b0;
  logic ot = 1'b0;
  logic pin;
  logic out_a;
  logic out_b;
  logic en;
  int errors = 0;
  int cmp_count = 0;
  int n;
  row_t rows[4];
  always #20 clock = ~clock;
  clock_source_model u_src (.clock(clock), .run(run), .half_cycles(half), .pin(pin));
  transformer_bridge_drive_control u_dut (.clock(clock), .resetn(resetn), .mode(mode),
    .clock_or_rate_pin(pin), .rate_setting(rate), .under_voltage(uv), .over_temp(ot),
    .drive_out_a(out_a), .drive_out_b(out_b), .enabled(en));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // wait for a level on a, b or enabled (0, 1, 2); cnt is cycles taken
  task automatic await(input int w, input logic lvl, input int bound, output int cnt);
    logic [2:0] v;
    for (cnt = 1; cnt <= bound; cnt++) begin
      @(negedge clock);
      v = {en, out_b, out_a};
      if (v[w] === lvl) return;
    end
    check({31'h0, v[w]}, {31'h0, lvl});
    conclude();
  endtask : await
  initial begin
    rows[0] = '{1'b1, 8'h00, 8'h0a, bridge_drive_pkg::half_period_fast};
    rows[1] = '{1'b1, 8'hff, 8'h0a, bridge_drive_pkg::half_period_slow};
    rows[2] = '{1'b0, 8'h00, 8'h0a, 20};
    rows[3] = '{1'b0, 8'h00, 8'h19, 50};
    repeat (5) @(negedge clock);
    check({29'h0, out_a, out_b, en}, 32'h0);
    resetn = 1'b1;
    foreach (rows[k]) begin
      mode = rows[k].md;
      rate = rows[k].rt;
      half = rows[k].hf;
      run = !rows[k].md;
      await(0, 1'b0, 2000, n);
      await(0, 1'b1, 2000, n);
      await(1, 1'b1, 400, n);
      check(n, rows[k].span);
      $display("row %0d done", k);
    end
    run = 1'b0;
    await(2, 1'b0, 1405, n);
    check({31'h0, n > 300}, 32'h1);
    // hold the stall past the longest timeout so the checker's count saturates
    repeat (1100) @(negedge clock);
    check({29'h0, out_a, out_b, en}, 32'h0);
    run = 1'b1;
    await(2, 1'b1, 40, n);
    $display("watchdog done");
    mode = 1'b1;
    run = 1'b0;
    await(2, 1'b1, 300, n);
    mode = 1'b0;
    await(2, 1'b0, 1405, n);
    mode = 1'b1;
    await(2, 1'b1, 300, n);
    $display("disable done");
    for (int j = 0; j < 2; j++) begin
      {ot, uv} = j[0] ? 2'b10 : 2'b01;
      await(2, 1'b0, 8, n);
      {ot, uv} = 2'b00;
      await(2, 1'b1, 300, n);
    end
    $display("protection done");
    resetn = 1'b0;
    @(negedge clock);
    check({29'h0, out_a, out_b, en}, 32'h0);
    resetn = 1'b1;
    await(2, 1'b1, 300, n);
    $display("reset done");
    conclude();
  end
endmodule : tb
